// ---- rtl/mia_core_ctrl.sv ----
`timescale 1ns/1ps
module mia_core_ctrl #(
    parameter bit LEVEL_SENS = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_n,
    input wire logic timer_pin,
    input wire logic stop_exec,
    input wire logic insn_valid,
    input wire mia_pkg::mia_insn_t insn,
    input wire logic insn_end,
    input wire logic [4:0] rti_cc,
    output mia_pkg::mia_dec_t dec,
    output logic dec_valid,
    output logic entry,
    output logic [15:0] vector,
    output logic [4:0] cc,
    output logic [7:0] timer_count
);
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff, tpin_q_ff, irq_q_ff, ext_lat_ff;
    logic [4:0] cc_ff;
    logic [3:0] tctl_ff;
    logic [7:0] tcnt_ff;
    mia_pkg::mia_dec_t dec_ff, nxt_dec;
    logic dec_valid_ff, entry_ff;
    logic [15:0] vector_ff;
    logic tick, ext_pend, tmr_pend, take_ext, take_tmr, take_trap;
    logic is_ret, bit_tested, apb_setup, apb_wr, addr_hit;

    // PC plus a small step, kept at 16 bits
    function automatic logic [15:0] pc_add(input logic [15:0] p,
                                           input logic [1:0] n);
        pc_add = p + {14'h0000, n};
    endfunction : pc_add

    // Signed 8-bit offset from a base address
    function automatic logic [15:0] rel_tgt(input logic [15:0] base,
                                            input logic [7:0] off);
        rel_tgt = base + {{8{off[7]}}, off};
    endfunction : rel_tgt

    // Branch test: pair of opcodes per test, odd one inverted
    function automatic logic br_cond(input logic [3:0] nib,
                                     input logic [4:0] c,
                                     input logic pin_n);
        logic base;
        base = 1'b1;
        unique case (nib[3:1])
            3'd0: base = 1'b1;
            3'd1: base = ~(c[mia_pkg::CC_C] | c[mia_pkg::CC_Z]);
            3'd2: base = ~c[mia_pkg::CC_C];
            3'd3: base = ~c[mia_pkg::CC_Z];
            3'd4: base = ~c[mia_pkg::CC_H];
            3'd5: base = ~c[mia_pkg::CC_N];
            3'd6: base = ~c[mia_pkg::CC_I];
            3'd7: base = ~pin_n;
        endcase
        br_cond = base ^ nib[0];
    endfunction : br_cond

    // ten mode codes
    // Mode follows the opcode's high nibble
    function automatic mia_pkg::mia_mode_t mode_of(input logic [7:0] op);
        unique case (op[7:4])
            4'h0: mode_of = mia_pkg::MIA_MD_BTB;
            4'h1: mode_of = mia_pkg::MIA_MD_BSC;
            4'h2: mode_of = mia_pkg::MIA_MD_REL;
            4'h3, 4'hb: mode_of = mia_pkg::MIA_MD_DIR;
            4'h6, 4'he: mode_of = mia_pkg::MIA_MD_IX1;
            4'h7, 4'hf: mode_of = mia_pkg::MIA_MD_IX0;
            4'ha: mode_of = mia_pkg::MIA_MD_IMM;
            4'hc: mode_of = mia_pkg::MIA_MD_EXT;
            4'hd: mode_of = mia_pkg::MIA_MD_IX2;
            default: mode_of = mia_pkg::MIA_MD_INH;
        endcase
    endfunction : mode_of

    // five classes
    // Class also follows the high nibble of the opcode
    function automatic mia_pkg::mia_cls_t cls_of(input logic [7:0] op);
        unique case (op[7:4])
            4'h0, 4'h1: cls_of = mia_pkg::MIA_CLS_BIT;
            4'h2: cls_of = mia_pkg::MIA_CLS_BRANCH;
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7: cls_of = mia_pkg::MIA_CLS_RMW;
            4'h8, 4'h9: cls_of = mia_pkg::MIA_CLS_CTRL;
            default: cls_of = mia_pkg::MIA_CLS_REGMEM;
        endcase
    endfunction : cls_of

    // Decode of the instruction now presented
    always_comb
    begin
        nxt_dec = '0;
        nxt_dec.cls = cls_of(insn.opcode);
        nxt_dec.mode = mode_of(insn.opcode);
        nxt_dec.wr_data = insn.rd_data;
        bit_tested = insn.rd_data[insn.opcode[3:1]];
        unique case (nxt_dec.mode)
            mia_pkg::MIA_MD_INH: nxt_dec.next_pc = pc_add(insn.pc, 2'd1);
            mia_pkg::MIA_MD_IMM:
            begin
                nxt_dec.effective_address = pc_add(insn.pc, 2'd1);
                nxt_dec.ea_valid = 1'b1;
                nxt_dec.next_pc = pc_add(insn.pc, 2'd2);
            end
            mia_pkg::MIA_MD_DIR:
            begin
                nxt_dec.effective_address = {8'h00, insn.opnd1};
                nxt_dec.ea_valid = 1'b1;
                nxt_dec.next_pc = pc_add(insn.pc, 2'd2);
            end
            mia_pkg::MIA_MD_EXT:
            begin
                nxt_dec.effective_address = {insn.opnd1, insn.opnd2};
                nxt_dec.ea_valid = 1'b1;
                nxt_dec.next_pc = pc_add(insn.pc, 2'd3);
            end
            // Index register lives in the datapath, not here
            mia_pkg::MIA_MD_IX0: nxt_dec.next_pc = pc_add(insn.pc, 2'd1);
            mia_pkg::MIA_MD_IX1: nxt_dec.next_pc = pc_add(insn.pc, 2'd2);
            mia_pkg::MIA_MD_IX2: nxt_dec.next_pc = pc_add(insn.pc, 2'd3);
            mia_pkg::MIA_MD_REL:
            begin
                nxt_dec.taken = br_cond(insn.opcode[3:0], cc_ff, irq_n);
                nxt_dec.next_pc = nxt_dec.taken ?
                    rel_tgt(pc_add(insn.pc, 2'd2), insn.opnd1) :
                    pc_add(insn.pc, 2'd2);
            end
            mia_pkg::MIA_MD_BSC:
            begin
                // low page bit set or clear
                nxt_dec.effective_address = {8'h00, insn.opnd1};
                nxt_dec.ea_valid = 1'b1;
                nxt_dec.next_pc = pc_add(insn.pc, 2'd2);
                nxt_dec.wr_back = 1'b1;
                nxt_dec.wr_data[insn.opcode[3:1]] = ~insn.opcode[0];
            end
            mia_pkg::MIA_MD_BTB:
            begin
                nxt_dec.effective_address = {8'h00, insn.opnd1};
                nxt_dec.ea_valid = 1'b1;
                nxt_dec.taken = bit_tested ^ insn.opcode[0];
                nxt_dec.next_pc = nxt_dec.taken ?
                    rel_tgt(pc_add(insn.pc, 2'd3), insn.opnd2) :
                    pc_add(insn.pc, 2'd3);
            end
        endcase
        if (nxt_dec.cls == mia_pkg::MIA_CLS_REGMEM && nxt_dec.ea_valid &&
            nxt_dec.mode != mia_pkg::MIA_MD_IMM &&
            (insn.opcode[3:0] == mia_pkg::NIB_JUMP ||
             insn.opcode[3:0] == mia_pkg::NIB_CALL))
        begin
            nxt_dec.next_pc = nxt_dec.effective_address;
            nxt_dec.taken = 1'b1;
        end
        if (nxt_dec.cls == mia_pkg::MIA_CLS_REGMEM &&
            nxt_dec.mode != mia_pkg::MIA_MD_IMM &&
            (insn.opcode[3:0] == mia_pkg::NIB_STORE_A ||
             insn.opcode[3:0] == mia_pkg::NIB_STORE_X))
        begin
            nxt_dec.wr_back = 1'b1;
        end
        if (nxt_dec.cls == mia_pkg::MIA_CLS_RMW)
        begin
            nxt_dec.wr_back = insn.opcode[3:0] != mia_pkg::NIB_TEST_NZ;
        end
    end

    // Decoder output is held until the next instruction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dec_ff <= '0;
            dec_valid_ff <= 1'b0;
        end
        else
        begin
            dec_valid_ff <= insn_valid;
            if (insn_valid)
            begin
                dec_ff <= nxt_dec;
            end
        end
    end

    always_comb
    begin
        unique case ({tctl_ff[mia_pkg::TC_DIS - 4],
                      tctl_ff[mia_pkg::TC_GATE - 4]})
            2'b00: tick = 1'b1;
            2'b01: tick = timer_pin;
            2'b10: tick = 1'b0;
            2'b11: tick = tpin_q_ff & ~timer_pin;
        endcase
    end

    // Previous pin levels for falling-edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tpin_q_ff <= 1'b0;
            irq_q_ff <= 1'b1;
        end
        else
        begin
            tpin_q_ff <= timer_pin;
            irq_q_ff <= irq_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tcnt_ff <= mia_pkg::TMR_PRESET;
        else if (stop_exec)
            tcnt_ff <= mia_pkg::TMR_PRESET;
        else if (tick)
            tcnt_ff <= tcnt_ff - 8'h01;
    end

    // Timer control; request sets on 01 to 00, set beats clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tctl_ff <= mia_pkg::TCTL_RST;
        end
        else
        begin
            if (apb_wr && paddr == mia_pkg::REG_TCTL)
            begin
                tctl_ff <= pwdata[7:4];
            end
            if (tick && tcnt_ff == 8'h01)
            begin
                tctl_ff[mia_pkg::TC_REQ - 4] <= 1'b1;
            end
        end
    end

    assign ext_pend = ext_lat_ff | (LEVEL_SENS & ~irq_n);
    assign tmr_pend = tctl_ff[mia_pkg::TC_REQ - 4] &
                      ~tctl_ff[mia_pkg::TC_MASK - 4];
    assign take_ext = insn_end & ~cc_ff[mia_pkg::CC_I] & ext_pend;
    assign take_tmr = insn_end & ~cc_ff[mia_pkg::CC_I] & ~ext_pend &
                      tmr_pend;
    assign take_trap = insn_valid & ~take_ext & ~take_tmr &
                       insn.opcode == mia_pkg::OP_SW_TRAP;
    assign is_ret = insn_valid & insn.opcode == mia_pkg::OP_RET_TRAP;

    // edge latch; an edge in the entry cycle is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_lat_ff <= 1'b0;
        end
        else if (irq_q_ff && !irq_n)
        begin
            ext_lat_ff <= 1'b1;
        end
        else if (take_ext)
        begin
            ext_lat_ff <= 1'b0;
        end
    end

    // Entry pulse tells the core to stack and fetch the vector
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            entry_ff <= 1'b0;
            vector_ff <= 16'h0000;
        end
        else
        begin
            entry_ff <= take_ext | take_tmr | take_trap;
            if (take_ext)
            begin
                vector_ff <= mia_pkg::VEC_EXT;
            end
            else if (take_tmr)
            begin
                vector_ff <= mia_pkg::VEC_TMR;
            end
            else if (take_trap)
            begin
                vector_ff <= mia_pkg::VEC_TRAP;
            end
        end
    end

    // Condition codes; hardware updates win over software writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cc_ff <= mia_pkg::CC_RST;
        end
        else if (take_ext || take_tmr || take_trap)
        begin
            cc_ff[mia_pkg::CC_I] <= 1'b1;
        end
        else if (is_ret)
        begin
            cc_ff <= rti_cc;
        end
        else if (insn_valid && mode_of(insn.opcode) == mia_pkg::MIA_MD_BTB)
        begin
            cc_ff[mia_pkg::CC_C] <= bit_tested;
        end
        else if (apb_wr && paddr == mia_pkg::REG_CC)
        begin
            cc_ff <= pwdata[4:0];
        end
    end

    // Bus slave answers in the access phase with no wait states
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready_ff & pwrite & addr_hit;
    assign addr_hit = paddr == mia_pkg::REG_CC ||
                      paddr == mia_pkg::REG_TCTL ||
                      paddr == mia_pkg::REG_TCNT ||
                      paddr == mia_pkg::REG_STAT;

    // Read data is latched during setup so it stands all access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup & ~addr_hit;
            prdata_ff <= 32'h0000_0000;
            if (apb_setup && !pwrite)
            begin
                unique case (paddr)
                    mia_pkg::REG_CC: prdata_ff[4:0] <= cc_ff;
                    mia_pkg::REG_TCTL: prdata_ff[7:4] <= tctl_ff;
                    mia_pkg::REG_TCNT: prdata_ff[7:0] <= tcnt_ff;
                    mia_pkg::REG_STAT:
                        prdata_ff[3:0] <= {LEVEL_SENS, ext_lat_ff,
                                           tmr_pend, ext_pend};
                    default: prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign dec = dec_ff;
    assign dec_valid = dec_valid_ff;
    assign entry = entry_ff;
    assign vector = vector_ff;
    assign cc = cc_ff;
    assign timer_count = tcnt_ff;
endmodule : mia_core_ctrl

// ---- rtl/mia_pkg.sv ----
// Operation
// - Unmasked low interrupt pin causes entry
// - External entry like timer, vector 1FFA
// - Build option: level-and-edge or edge only
// - Level build only: line still low gives another entry
// - Software trap enters regardless of mask
// - Software trap vectors through 1FFC
// - Gate mode: clock ANDed with pin
// - Disable-only mode blocks all counting
// - Both bits: count pin falling edges
// - Reset and stop preset counter F0
// - Decode 61 instructions in five classes
// - Register/memory ops; jump, call load PC in direct and extended modes
// - Read/modify/write writes back, except test
// - Taken branch adds signed offset to PC
// - Bit set, clear, test in low page
// - Bit test copies bit into carry
// - Ten addressing modes; immediate, direct, extended and bit modes form the address
// - Inherent mode has no operand bytes
// - Immediate: address PC+1, PC advances two
// - Direct: high byte zero, PC plus two
// - External interrupt served before timer
// - Entry stacks, sets mask; return restores
// - Interrupt waits for instruction end
package mia_pkg;
    localparam logic [11:0] REG_CC = 12'h000;
    localparam logic [11:0] REG_TCTL = 12'h004;
    localparam logic [11:0] REG_TCNT = 12'h008;
    localparam logic [11:0] REG_STAT = 12'h00c;
    // Condition code bit positions
    localparam int CC_C = 0;
    localparam int CC_Z = 1;
    localparam int CC_N = 2;
    localparam int CC_I = 3;
    localparam int CC_H = 4;
    localparam logic [4:0] CC_RST = 5'h08;
    // Timer control bit positions within the byte
    localparam int TC_GATE = 4;
    localparam int TC_DIS = 5;
    localparam int TC_MASK = 6;
    localparam int TC_REQ = 7;
    localparam logic [3:0] TCTL_RST = 4'h4;
    localparam logic [7:0] TMR_PRESET = 8'hf0;
    localparam logic [15:0] VEC_TMR = 16'h1ff8;
    localparam logic [15:0] VEC_EXT = 16'h1ffa;
    localparam logic [15:0] VEC_TRAP = 16'h1ffc;
    localparam logic [7:0] OP_RET_TRAP = 8'h80;
    localparam logic [7:0] OP_SW_TRAP = 8'h83;
    localparam logic [3:0] NIB_TEST_NZ = 4'hd;
    localparam logic [3:0] NIB_JUMP = 4'hc;
    localparam logic [3:0] NIB_CALL = 4'hd;
    localparam logic [3:0] NIB_STORE_A = 4'h7;
    localparam logic [3:0] NIB_STORE_X = 4'hf;
    localparam int BASE_INSN_CNT = 61;

    typedef enum logic [2:0] {
        MIA_CLS_REGMEM = 3'b000,
        MIA_CLS_RMW = 3'b001,
        MIA_CLS_BRANCH = 3'b010,
        MIA_CLS_BIT = 3'b011,
        MIA_CLS_CTRL = 3'b100
    } mia_cls_t;

    typedef enum logic [3:0] {
        MIA_MD_INH = 4'b0000,
        MIA_MD_IMM = 4'b0001,
        MIA_MD_DIR = 4'b0010,
        MIA_MD_EXT = 4'b0011,
        MIA_MD_IX0 = 4'b0100,
        MIA_MD_IX1 = 4'b0101,
        MIA_MD_IX2 = 4'b0110,
        MIA_MD_REL = 4'b0111,
        MIA_MD_BSC = 4'b1000,
        MIA_MD_BTB = 4'b1001
    } mia_mode_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] opnd1;
        logic [7:0] opnd2;
        logic [15:0] pc;
        logic [7:0] rd_data;
    } mia_insn_t;

    typedef struct packed {
        mia_cls_t cls;
        mia_mode_t mode;
        logic [15:0] effective_address;
        logic ea_valid;
        logic [15:0] next_pc;
        logic wr_back;
        logic [7:0] wr_data;
        logic taken;
    } mia_dec_t;
endpackage : mia_pkg

// ---- verif/mia_core_ctrl_monitor.sv ----
`timescale 1ns/1ps
module mia_ctrl_monitor #(
    parameter bit LEVEL_SENS = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic irq_n,
    input wire logic stop_exec,
    input wire logic insn_valid,
    input wire mia_pkg::mia_insn_t insn,
    input wire logic insn_end,
    input wire mia_pkg::mia_dec_t dec,
    input wire logic dec_valid,
    input wire logic entry,
    input wire logic [15:0] vector,
    input wire logic [4:0] cc,
    input wire logic [7:0] timer_count
);
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Bus answer one cycle after setup
    property p_setup_ready;
        psel && !penable |=> pready && psel && penable;
    endproperty
    a_setup_ready: assert property (p_setup_ready) else $error("no ready");
    property p_dec_pulse;
        insn_valid |=> dec_valid;
    endproperty
    a_dec_pulse: assert property (p_dec_pulse) else $error("no decode");
    property p_imm_ea;
        insn_valid && insn.opcode[7:4] == 4'ha |=>
            dec.effective_address == $past(insn.pc) + 16'h0001 &&
            dec.next_pc == $past(insn.pc) + 16'h0002;
    endproperty
    a_imm_ea: assert property (p_imm_ea) else $error("bad imm");
    property p_dir_ea;
        insn_valid && insn.opcode[6:4] == 3'h3 |=>
            dec.effective_address == {8'h00, $past(insn.opnd1)};
    endproperty
    a_dir_ea: assert property (p_dir_ea) else $error("bad direct");
    property p_tst_keep;
        insn_valid && insn.opcode[3:0] == mia_pkg::NIB_TEST_NZ &&
            insn.opcode[7:4] inside {4'h3, 4'h4, 4'h5} |=> !dec.wr_back;
    endproperty
    a_tst_keep: assert property (p_tst_keep) else $error("test wrote");
    property p_ext_take;
        LEVEL_SENS && insn_end && !cc[mia_pkg::CC_I] && !irq_n |=>
            entry && vector == mia_pkg::VEC_EXT;
    endproperty
    a_ext_take: assert property (p_ext_take) else $error("no ext");
    property p_trap;
        insn_valid && insn.opcode == mia_pkg::OP_SW_TRAP && !insn_end |=>
            entry && vector == mia_pkg::VEC_TRAP;
    endproperty
    a_trap: assert property (p_trap) else $error("no trap entry");
    property p_entry_mask;
        entry |-> cc[mia_pkg::CC_I];
    endproperty
    a_entry_mask: assert property (p_entry_mask) else $error("mask");
    property p_masked_wait;
        insn_end && cc[mia_pkg::CC_I] && !insn_valid |=> !entry;
    endproperty
    a_masked_wait: assert property (p_masked_wait) else $error("masked");
    property p_stop_preset;
        stop_exec |=> timer_count == mia_pkg::TMR_PRESET;
    endproperty
    a_stop_preset: assert property (p_stop_preset) else $error("preset");
    property p_btb_carry;
        insn_valid && insn.opcode[7:4] == 4'h0 |=>
            cc[mia_pkg::CC_C] == $past(insn.rd_data[insn.opcode[3:1]]);
    endproperty
    a_btb_carry: assert property (p_btb_carry) else $error("carry");
    // Main scenarios reached
    c_ext: cover property (entry && vector == mia_pkg::VEC_EXT);
    c_trap: cover property (entry && vector == mia_pkg::VEC_TRAP);
    c_taken: cover property (dec_valid && dec.taken);
endmodule : mia_ctrl_monitor

bind mia_core_ctrl mia_ctrl_monitor #(.LEVEL_SENS(LEVEL_SENS)) u_mon (
    .pclk, .presetn, .psel, .penable, .pready, .irq_n, .stop_exec,
    .insn_valid, .insn, .insn_end, .dec, .dec_valid, .entry, .vector,
    .cc, .timer_count
);

// ---- verif/mia_src_model.sv ----
`timescale 1ns/1ps
module mia_src_model #(
    parameter int HALF = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] src_low,
    input wire logic pulse,
    input wire logic tpin_run,
    input wire logic tpin_idle,
    output logic irq_n,
    output logic timer_pin
);
    logic [1:0] pw_cnt_ff;
    logic [7:0] ph_cnt_ff;
    // one pulse per command
    // The bench only asks again once the routine has returned
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pw_cnt_ff <= 2'h0;
        else if (pulse)
            pw_cnt_ff <= 2'h3;
        else if (pw_cnt_ff != 2'h0)
            pw_cnt_ff <= pw_cnt_ff - 2'h1;
    end
    // Open-drain sources over a pull-up, so any one pulls low
    assign irq_n = !(|src_low) && (pw_cnt_ff == 2'h0);
    // Phase only runs in a burst, so edge counts stay exact
    always_ff @(posedge pclk)
    begin
        if (!tpin_run)
            ph_cnt_ff <= 8'h00;
        else if (ph_cnt_ff == 8'(2 * HALF - 1))
            ph_cnt_ff <= 8'h00;
        else
            ph_cnt_ff <= ph_cnt_ff + 8'h01;
    end
    assign timer_pin = tpin_run ? (ph_cnt_ff < 8'(HALF)) : tpin_idle;
endmodule : mia_src_model

// ---- verif/tb_mcu_core_interrupt_addressing.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end end
module tb_mcu_core_interrupt_addressing;
    logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic irq_n, timer_pin, stop_exec = 1'b0, insn_valid = 1'b0;
    logic insn_end = 1'b0, dec_valid, entry, entry2, pulse = 1'b0;
    logic tpin_run = 1'b0, tpin_idle = 1'b1;
    logic [1:0] src_low = 2'b00;
    logic [4:0] rti_cc = 5'h00, cc;
    logic [7:0] timer_count, c0;
    logic [15:0] vector;
    mia_pkg::mia_insn_t insn = '0;
    mia_pkg::mia_dec_t dec;
    int err_count, total_checks;

    mia_core_ctrl #(.LEVEL_SENS(1'b1)) dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .irq_n, .timer_pin, .stop_exec,
        .insn_valid, .insn, .insn_end, .rti_cc, .dec, .dec_valid, .entry,
        .vector, .cc, .timer_count
    );
    // Edge-only build sees the same stimulus
    mia_core_ctrl #(.LEVEL_SENS(1'b0)) dut_edge (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata(), .pready(), .pslverr(), .irq_n, .timer_pin, .stop_exec,
        .insn_valid, .insn, .insn_end, .rti_cc, .dec(), .dec_valid(),
        .entry(entry2), .vector(), .cc(), .timer_count()
    );
    mia_src_model #(.HALF(4)) u_src (
        .pclk, .presetn, .src_low, .pulse, .tpin_run, .tpin_idle, .irq_n,
        .timer_pin
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Bus cycle; waits on pready rather than assuming a latency
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Look mid-cycle, then release after the access edge
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            err_count++;
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic go(input logic [7:0] op, input logic [7:0] o1,
                      input logic [7:0] o2, input logic [15:0] pc,
                      input logic [7:0] rdd);
        @(posedge pclk);
        insn_valid <= 1'b1;
        insn <= {op, o1, o2, pc, rdd};
        @(posedge pclk);
        insn_valid <= 1'b0;
        #1;
    endtask : go

    task automatic fin_insn();
        @(posedge pclk);
        insn_end <= 1'b1;
        @(posedge pclk);
        insn_end <= 1'b0;
        #1;
    endtask : fin_insn

    task automatic t_apb();
        apb(mia_pkg::REG_TCTL, 1'b0, 32'h0000_0000);
        `CHK(rd[7:4], mia_pkg::TCTL_RST)
        apb(12'h010, 1'b0, 32'h0000_0000);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        apb(mia_pkg::REG_CC, 1'b1, 32'h0000_0015);
        apb(mia_pkg::REG_CC, 1'b0, 32'h0000_0000);
        `CHK(rd[4:0], 5'h15)
    endtask : t_apb

    task automatic t_timer();
        @(posedge pclk);
        stop_exec <= 1'b1;
        @(posedge pclk);
        stop_exec <= 1'b0;
        #1;
        `CHK(timer_count, mia_pkg::TMR_PRESET)
        tpin_run <= 1'b1;
        apb(mia_pkg::REG_TCTL, 1'b1, 32'h0000_0060);
        #1 c0 = timer_count;
        repeat (20) @(posedge pclk);
        #1 `CHK(timer_count, c0)
        tpin_run <= 1'b0;
        tpin_idle <= 1'b0;
        apb(mia_pkg::REG_TCTL, 1'b1, 32'h0000_0050);
        #1 c0 = timer_count;
        tpin_run <= 1'b1;
        repeat (32) @(posedge pclk);
        tpin_run <= 1'b0;
        repeat (4) @(posedge pclk);
        #1 `CHK(8'(c0 - timer_count), 8'h10)
        apb(mia_pkg::REG_TCTL, 1'b1, 32'h0000_0060);
        tpin_idle <= 1'b1;
        apb(mia_pkg::REG_TCTL, 1'b1, 32'h0000_0070);
        #1 c0 = timer_count;
        tpin_run <= 1'b1;
        repeat (64) @(posedge pclk);
        tpin_run <= 1'b0;
        repeat (4) @(posedge pclk);
        #1 `CHK(8'(c0 - timer_count), 8'h08)
    endtask : t_timer

    task automatic t_dec();
        go(8'ha6, 8'h00, 8'h00, 16'h0100, 8'h00);
        `CHK(dec.mode, mia_pkg::MIA_MD_IMM)
        `CHK({dec.effective_address, dec.next_pc}, 32'h0101_0102)
        go(8'hb6, 8'h35, 8'h00, 16'h0200, 8'h00);
        `CHK(dec.mode, mia_pkg::MIA_MD_DIR)
        `CHK({dec.effective_address, dec.next_pc}, 32'h0035_0202)
        go(8'h4c, 8'h00, 8'h00, 16'h0300, 8'h00);
        `CHK({dec.mode, dec.next_pc}, {mia_pkg::MIA_MD_INH, 16'h0301})
        `CHK({dec.cls, dec.wr_back}, {mia_pkg::MIA_CLS_RMW, 1'b1})
        go(8'h3d, 8'h20, 8'h00, 16'h0300, 8'h00);
        `CHK({dec.cls, dec.wr_back}, {mia_pkg::MIA_CLS_RMW, 1'b0})
        go(8'hbc, 8'h40, 8'h00, 16'h0400, 8'h00);
        `CHK({dec.cls, dec.next_pc}, {mia_pkg::MIA_CLS_REGMEM, 16'h0040})
        go(8'h20, 8'h80, 8'h00, 16'h0500, 8'h00);
        `CHK({dec.cls, dec.taken}, {mia_pkg::MIA_CLS_BRANCH, 1'b1})
        `CHK(dec.next_pc, 16'h0482)
        go(8'h20, 8'h7f, 8'h00, 16'h0500, 8'h00);
        `CHK(dec.next_pc, 16'h0581)
        go(8'h10, 8'h12, 8'h00, 16'h0500, 8'h00);
        `CHK({dec.cls, dec.effective_address}, {mia_pkg::MIA_CLS_BIT, 16'h0012})
        go(8'h0e, 8'h10, 8'h05, 16'h0600, 8'h80);
        `CHK({dec.taken, dec.next_pc}, {1'b1, 16'h0608})
        `CHK(cc[mia_pkg::CC_C], 1'b1)
        go(8'h0f, 8'h10, 8'h05, 16'h0600, 8'h00);
        `CHK(cc[mia_pkg::CC_C], 1'b0)
        go(8'h9d, 8'h00, 8'h00, 16'h0700, 8'h00);
        `CHK(dec.cls, mia_pkg::MIA_CLS_CTRL)
    endtask : t_dec

    task automatic t_irq();
        apb(mia_pkg::REG_CC, 1'b1, 32'h0000_0000);
        src_low <= 2'b01;
        fin_insn();
        `CHK({entry, entry2, vector}, {2'b11, mia_pkg::VEC_EXT})
        `CHK(cc[mia_pkg::CC_I], 1'b1)
        rti_cc <= 5'h00;
        go(mia_pkg::OP_RET_TRAP, 8'h00, 8'h00, 16'h0000, 8'h00);
        `CHK(cc, 5'h00)
        fin_insn();
        `CHK({entry, entry2}, 2'b10)
        src_low <= 2'b00;
        rti_cc <= 5'h08;
        go(mia_pkg::OP_RET_TRAP, 8'h00, 8'h00, 16'h0000, 8'h00);
        pulse <= 1'b1;
        @(posedge pclk);
        pulse <= 1'b0;
        repeat (4) @(posedge pclk);
        fin_insn();
        `CHK({entry, entry2}, 2'b00)
        apb(mia_pkg::REG_CC, 1'b1, 32'h0000_0000);
        fin_insn();
        `CHK({entry, entry2, vector}, {2'b11, mia_pkg::VEC_EXT})
        go(mia_pkg::OP_SW_TRAP, 8'h00, 8'h00, 16'h0700, 8'h00);
        `CHK({entry, vector}, {1'b1, mia_pkg::VEC_TRAP})
    endtask : t_irq

    task automatic t_prio();
        apb(mia_pkg::REG_TCTL, 1'b1, 32'h0000_0000);
        for (int i = 0; i < 150 && rd[1] !== 1'b1; i++)
            apb(mia_pkg::REG_STAT, 1'b0, 32'h0000_0000);
        `CHK(rd[1], 1'b1)
        src_low <= 2'b10;
        apb(mia_pkg::REG_CC, 1'b1, 32'h0000_0000);
        fin_insn();
        `CHK({entry, vector}, {1'b1, mia_pkg::VEC_EXT})
        src_low <= 2'b00;
        apb(mia_pkg::REG_CC, 1'b1, 32'h0000_0000);
        fin_insn();
        `CHK({entry, vector}, {1'b1, mia_pkg::VEC_TMR})
        apb(mia_pkg::REG_TCTL, 1'b1, 32'h0000_0040);
    endtask : t_prio

    // Far beyond what the scenarios need
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        finish_test();
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        `CHK(cc, mia_pkg::CC_RST)
        `CHK(timer_count, mia_pkg::TMR_PRESET)
        presetn <= 1'b1;
        t_apb();
        t_timer();
        t_dec();
        t_irq();
        t_prio();
        finish_test();
    end
endmodule : tb_mcu_core_interrupt_addressing
